/* pkg/ltu_map.svh */
/*
 Constants of the logical address test unit: register offsets, status field positions,
 reset values and exception vectors.
 Assumes inclusion by bare name from the package and the bench.
*/
`ifndef LTU_MAP_SVH
`define LTU_MAP_SVH
`define LTU_CTRL_OFS 12'h000
`define LTU_CMD_OFS 12'h004
`define LTU_EA_OFS 12'h008
`define LTU_STAT_OFS 12'h00c
`define LTU_RET_OFS 12'h010
`define LTU_SRC_OFS 12'h014
`define LTU_DATA_OFS 12'h018
`define LTU_ENA_BIT 0
`define LTU_SUP_BIT 1
`define LTU_ST_B 15
`define LTU_ST_L 14
`define LTU_ST_S 13
`define LTU_ST_A 11
`define LTU_ST_W 10
`define LTU_ST_I 9
`define LTU_ST_M 8
`define LTU_ST_G 7
`define LTU_ST_C 6
`define LTU_STAT_RST 16'h0000
`define LTU_VEC_ILLOP 8'h39
`define LTU_VEC_FLINE 8'h0b
`define LTU_VEC_PRIV 8'h08
`endif

/* pkg/ltu_pkg.sv */
/*
 Types of the logical address test unit.
 Assumes ltu_map.svh is on the include path.
*/
`include "ltu_map.svh"
package ltu_pkg;
   typedef enum logic [2:0] {
      LTU_IDLE = 3'b000,
      LTU_LOOK = 3'b001,
      LTU_FETCH = 3'b010,
      LTU_WAIT = 3'b011,
      LTU_DONE = 3'b100
   } ltu_state_t;
   // One descriptor as returned by the table fetch port
   typedef struct packed {
      logic is_long;
      logic [1:0] dtype;
      logic wp;
      logic sup;
      logic [2:0] read_access_level;
      logic [2:0] write_access_level;
      logic mod;
      logic gate;
      logic shared;
      logic lim_hit;
   } ltu_desc_t;
   // Cache lookup answer
   typedef struct packed {
      logic hit;
      logic fetch_fault_bit;
      logic wp;
      logic mod;
      logic gate;
      logic shared;
      logic sup;
   } ltu_cache_t;
endpackage

/* rtl/ltu_test_unit.sv */
/*
 Logical address test unit: runs a probe command over the translation cache or a
 bounded table walk, accumulates status, and can return the last descriptor address.
 Assumes an APB master for software, an external cache lookup answering in one cycle,
 and a descriptor fetch port with a request/valid handshake on CORE_CLK.
*/
// Notes on behaviour
// - Probe acts only in supervisor state; user state traps and keeps status.
// - Translation disabled raises illegal-operation vector 39 hex, status untouched.
// - Space-code field picks immediate, data register, source or destination register.
// - Depth zero searches cache only; 1 to 7 walk tables, bounded fetches.
// - Read/write select chooses read or write access rule for violation flag.
// - Result field 1RRR returns last descriptor address to register RRR.
// - Depth zero with nonzero result field raises F-line exception.
// - Returned address is that of last descriptor fetched without bus fault.
// - Root pointer of page type returns address zero.
// - Walk stops at depth, invalid type, page descriptor, limit or fault; flags other than invalid accumulate.
// - Walk never writes used or modified bits in memory.
// - Fault flag from any fetch fault or cache entry fault bit.
// - Limit flag when address exceeds a long descriptor's limit.
// - Supervisor flag when long descriptor is supervisor-only and space bit 2 low.
// - Access flag from read level, or read or write level for writes.
// - Write-protect flag from any protect bit or write level denial.
// - Invalid flag when no valid translation exists.
// - Modified and gate copied from cache hit, else page descriptor.
// - Shared flag when the tested address is globally shared.
// - Level count is levels searched; zero for depth zero or page root.
// - Only some flags must agree between cache lookup and walk.
`timescale 1ns/1ns
module ltu_test_unit
   import ltu_pkg::*;
(
   input wire logic CORE_CLK, // 25 MHz core clock
   input wire logic RESETN, // Asynchronous reset, active low
   input wire logic PSEL, // APB select
   input wire logic PENABLE, // APB enable
   input wire logic PWRITE, // APB write
   input wire logic [11:0] PADDR, // APB byte address
   input wire logic [31:0] PWDATA, // APB write data
   output logic [31:0] PRDATA, // APB read data
   output logic PREADY, // APB ready
   output logic PSLVERR, // APB error on unmapped address
   output logic CACHE_REQ, // Cache lookup request
   output logic [31:0] CACHE_ADDR, // Tested address for lookup
   output logic [3:0] CACHE_SPACE, // Tested space code for lookup
   input wire ltu_cache_t CACHE_RSP, // Cache answer, valid cycle after request
   input wire logic [2:0] ACC_LEVEL, // Current access level for READ_ACCESS_LEVEL/WRITE_ACCESS_LEVEL compare
   output logic FETCH_REQ, // Descriptor fetch request, read only
   output logic [31:0] FETCH_ADDR, // Physical address of descriptor to fetch
   input wire logic FETCH_VLD, // Fetch complete
   input wire logic FETCH_FETCH_FAULT_BIT, // Fetch ended abnormally
   input wire ltu_desc_t FETCH_DESC, // Fetched descriptor fields
   input wire logic [31:0] FETCH_NEXT, // Next table address from descriptor
   input wire ltu_desc_t ROOT_DESC, // Root pointer in use
   input wire logic [31:0] ROOT_NEXT, // First table address from root pointer
   output logic EXC_VLD, // Exception pulse to processor
   output logic [7:0] EXC_VEC, // Exception vector
   output logic RET_VLD, // Address-register write pulse
   output logic [2:0] RET_REG, // Address register number
   output logic [31:0] RET_ADDR, // Last descriptor address
   output logic DONE // Command finished pulse
);
   // Software registers
   logic [1:0] ctrl_q;
   logic [15:0] cmd_q;
   logic [31:0] ea_q;
   logic [15:0] stat_q;
   logic [31:0] ret_q;
   logic [6:0] src_q;
   logic [31:0] data_q;
   logic go_q;
   ltu_state_t state_q;
   logic [2:0] depth_q;
   logic [2:0] lvl_q;
   logic [31:0] next_q;
   logic [31:0] last_q;
   logic [3:0] space_q;
   logic [15:0] acc_q;
   logic fetch_req_q;
   logic cache_req_q;
   logic exc_q;
   logic [7:0] vec_q;
   logic ret_vld_q;
   logic done_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   // Command word: [15:13] depth, [12] read, [11:8] result reg, [4:0] space select
   wire [2:0] c_depth = cmd_q[15:13];
   wire c_read = cmd_q[12];
   wire [3:0] c_areg = cmd_q[11:8];
   wire [4:0] c_fcsel = cmd_q[4:0];

   function automatic logic [3:0] pick_space(input logic [4:0] sel, input logic [6:0] src,
                                             input logic [31:0] dat);
      if (sel[4])
         pick_space = sel[3:0];
      else if (sel[3])
         pick_space = dat[3:0];
      else if (sel[0])
         pick_space = {1'b0, src[6:4]};
      else
         pick_space = {1'b0, src[2:0]};
   endfunction

   function automatic logic denies(input logic [2:0] lvl, input logic [2:0] cur);
      denies = cur > lvl;
   endfunction

   wire apb_acc = PSEL && PENABLE && !pready_q;
   // Writes land only at the edge that sees PREADY high, never on the first access edge
   wire apb_fin = PSEL && PENABLE && pready_q;
   wire apb_wr = apb_fin && PWRITE;
   wire mapped = (PADDR == `LTU_CTRL_OFS) || (PADDR == `LTU_CMD_OFS) ||
                 (PADDR == `LTU_EA_OFS) || (PADDR == `LTU_STAT_OFS) ||
                 (PADDR == `LTU_RET_OFS) || (PADDR == `LTU_SRC_OFS) ||
                 (PADDR == `LTU_DATA_OFS);
   wire cmd_wr = apb_wr && (PADDR == `LTU_CMD_OFS) && (state_q == LTU_IDLE);
   wire [31:0] rd_mux =
      (PADDR == `LTU_CTRL_OFS) ? {30'h0, ctrl_q} :
      (PADDR == `LTU_CMD_OFS) ? {16'h0, cmd_q} :
      (PADDR == `LTU_EA_OFS) ? ea_q :
      (PADDR == `LTU_STAT_OFS) ? {16'h0, stat_q} :
      (PADDR == `LTU_RET_OFS) ? ret_q :
      (PADDR == `LTU_SRC_OFS) ? {25'h0, src_q} :
      (PADDR == `LTU_DATA_OFS) ? data_q : 32'h0;

   // Descriptor flag contributions, accumulated over the walk
   wire d_long = FETCH_DESC.is_long;
   wire d_inval = FETCH_DESC.dtype == 2'h0;
   wire d_page = FETCH_DESC.dtype == 2'h1;
   wire ral_no = d_long && denies(FETCH_DESC.read_access_level, ACC_LEVEL);
   wire wal_no = d_long && denies(FETCH_DESC.write_access_level, ACC_LEVEL);
   wire d_sup = d_long && FETCH_DESC.sup && !space_q[2];
   wire d_acc = c_read ? ral_no : (ral_no || wal_no);
   wire d_wp = FETCH_DESC.wp || wal_no;
   wire d_lim = d_long && FETCH_DESC.lim_hit;
   wire [15:0] d_flags = ({15'h0, d_lim} << `LTU_ST_L) | ({15'h0, d_sup} << `LTU_ST_S) |
                         ({15'h0, d_acc} << `LTU_ST_A) | ({15'h0, d_wp} << `LTU_ST_W);
   wire walk_end = FETCH_FETCH_FAULT_BIT || d_inval || d_lim || d_page || (lvl_q + 3'h1 == depth_q);
   wire [15:0] page_bits = (d_page && !FETCH_FETCH_FAULT_BIT) ?
      (({15'h0, FETCH_DESC.mod} << `LTU_ST_M) | ({15'h0, FETCH_DESC.gate} << `LTU_ST_G) |
       ({15'h0, FETCH_DESC.shared} << `LTU_ST_C)) : 16'h0;
   // Invalid reflects the last level only; a faulted descriptor contributes no attributes
   wire [15:0] fetch_acc = (acc_q & ~(16'h1 << `LTU_ST_I)) |
      (FETCH_FETCH_FAULT_BIT ? 16'h0 : d_flags) | page_bits |
      ({15'h0, FETCH_FETCH_FAULT_BIT} << `LTU_ST_B) |
      ({15'h0, FETCH_FETCH_FAULT_BIT || d_inval || !d_page} << `LTU_ST_I);
   wire [15:0] cache_stat =
      ({15'h0, CACHE_RSP.hit && CACHE_RSP.fetch_fault_bit} << `LTU_ST_B) |
      ({15'h0, !CACHE_RSP.hit} << `LTU_ST_I) |
      ({15'h0, CACHE_RSP.hit && CACHE_RSP.wp} << `LTU_ST_W) |
      ({15'h0, CACHE_RSP.hit && CACHE_RSP.mod} << `LTU_ST_M) |
      ({15'h0, CACHE_RSP.hit && CACHE_RSP.gate} << `LTU_ST_G) |
      ({15'h0, CACHE_RSP.hit && CACHE_RSP.shared} << `LTU_ST_C) |
      ({15'h0, CACHE_RSP.hit && CACHE_RSP.sup && !space_q[2]} << `LTU_ST_S);
   wire root_page = ROOT_DESC.dtype == 2'h1;

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= PSEL && PENABLE && !pready_q;
         pslverr_q <= apb_acc && !mapped;
         prdata_q <= (apb_acc && !PWRITE) ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_q <= 2'h0;
         cmd_q <= 16'h0;
         ea_q <= 32'h0;
         src_q <= 7'h0;
         data_q <= 32'h0;
         go_q <= 1'b0;
      end else begin
         go_q <= cmd_wr;
         if (apb_wr && PADDR == `LTU_CTRL_OFS)
            ctrl_q <= PWDATA[1:0];
         if (cmd_wr)
            cmd_q <= PWDATA[15:0];
         if (apb_wr && PADDR == `LTU_EA_OFS)
            ea_q <= PWDATA;
         if (apb_wr && PADDR == `LTU_SRC_OFS)
            src_q <= PWDATA[6:0];
         if (apb_wr && PADDR == `LTU_DATA_OFS)
            data_q <= PWDATA;
      end
   end

   // Command sequencer; fetches are read-only so descriptors are never written back
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_q <= LTU_IDLE;
         depth_q <= 3'h0;
         lvl_q <= 3'h0;
         next_q <= 32'h0;
         last_q <= 32'h0;
         space_q <= 4'h0;
         acc_q <= 16'h0;
         stat_q <= `LTU_STAT_RST;
         ret_q <= 32'h0;
         fetch_req_q <= 1'b0;
         cache_req_q <= 1'b0;
         exc_q <= 1'b0;
         vec_q <= 8'h0;
         ret_vld_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         exc_q <= 1'b0;
         ret_vld_q <= 1'b0;
         done_q <= 1'b0;
         cache_req_q <= 1'b0;
         fetch_req_q <= 1'b0;
         case (state_q)
            LTU_IDLE: begin
               if (go_q) begin
                  space_q <= pick_space(c_fcsel, src_q, data_q);
                  depth_q <= c_depth;
                  lvl_q <= 3'h0;
                  acc_q <= 16'h0;
                  last_q <= 32'h0;
                  if (!ctrl_q[`LTU_SUP_BIT]) begin
                     exc_q <= 1'b1;
                     vec_q <= `LTU_VEC_PRIV;
                     done_q <= 1'b1;
                  end else if (c_depth == 3'h0 && c_areg != 4'h0) begin
                     exc_q <= 1'b1;
                     vec_q <= `LTU_VEC_FLINE;
                     done_q <= 1'b1;
                  end else if (!ctrl_q[`LTU_ENA_BIT]) begin
                     exc_q <= 1'b1;
                     vec_q <= `LTU_VEC_ILLOP;
                     done_q <= 1'b1;
                  end else if (c_depth == 3'h0) begin
                     cache_req_q <= 1'b1;
                     state_q <= LTU_LOOK;
                  end else if (root_page) begin
                     acc_q <= 16'h0;
                     state_q <= LTU_DONE;
                  end else begin
                     next_q <= ROOT_NEXT;
                     state_q <= LTU_FETCH;
                  end
               end
            end
            LTU_LOOK: begin
               // The cache answers the cycle after the request
               if (!CACHE_REQ) begin
                  acc_q <= cache_stat;
                  state_q <= LTU_DONE;
               end
            end
            LTU_FETCH: begin
               fetch_req_q <= 1'b1;
               state_q <= LTU_WAIT;
            end
            LTU_WAIT: begin
               if (FETCH_VLD) begin
                  acc_q <= fetch_acc;
                  lvl_q <= lvl_q + 3'h1;
                  if (!FETCH_FETCH_FAULT_BIT)
                     last_q <= next_q;
                  next_q <= FETCH_NEXT;
                  state_q <= walk_end ? LTU_DONE : LTU_FETCH;
               end
            end
            LTU_DONE: begin
               stat_q <= acc_q | {13'h0, lvl_q};
               if (c_areg[3]) begin
                  ret_vld_q <= 1'b1;
                  ret_q <= last_q;
               end
               done_q <= 1'b1;
               state_q <= LTU_IDLE;
            end
            default: state_q <= LTU_IDLE;
         endcase
      end
   end

   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign CACHE_REQ = cache_req_q;
   assign CACHE_ADDR = ea_q;
   assign CACHE_SPACE = space_q;
   assign FETCH_REQ = fetch_req_q;
   assign FETCH_ADDR = next_q;
   assign EXC_VLD = exc_q;
   assign EXC_VEC = vec_q;
   assign RET_VLD = ret_vld_q;
   assign RET_REG = cmd_q[10:8];
   assign RET_ADDR = ret_q;
   assign DONE = done_q;

   priv_trap_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      go_q && !ctrl_q[`LTU_SUP_BIT] |=> EXC_VLD && EXC_VEC == `LTU_VEC_PRIV && $stable(stat_q))
      else $error("user-state probe did not trap");
   disabled_trap_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      go_q && ctrl_q == 2'h2 && !(c_depth == 3'h0 && c_areg != 4'h0) |=>
      EXC_VEC == 8'h39 && EXC_VLD)
      else $error("disabled translation gave no illegal-op");
   fline_trap_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      go_q && ctrl_q[`LTU_SUP_BIT] && c_depth == 3'h0 && c_areg != 4'h0 |=>
      EXC_VLD && EXC_VEC == `LTU_VEC_FLINE)
      else $error("bad result field with depth zero not refused");
   cache_only_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      state_q == LTU_LOOK && !CACHE_REQ |-> !FETCH_REQ ##1 !FETCH_REQ ##1 stat_q[2:0] == 3'h0)
      else $error("depth-zero probe fetched or counted levels");
   depth_bound_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      FETCH_REQ |-> lvl_q < depth_q)
      else $error("walk exceeded requested depth");
   sequence done_seq;
      state_q == LTU_DONE ##1 DONE;
   endsequence
   status_once_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      $changed(stat_q) |-> $past(state_q) == LTU_DONE)
      else $error("status changed outside command end");
   ret_pulse_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      state_q == LTU_DONE && c_areg[3] |-> done_seq and (##1 RET_VLD && RET_ADDR == last_q))
      else $error("address return missing");
   fetch_fault_bit_keep_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      state_q == LTU_WAIT && FETCH_VLD && FETCH_FETCH_FAULT_BIT |=> $stable(last_q) && acc_q[`LTU_ST_B])
      else $error("faulted fetch counted as success");
endmodule

/* verification/logical_address_test_unit_test.sv */
/*
 Self-checking bench of the test unit: random probes with trap and register corners.
 Assumes the walk model answers the cache and fetch ports; the seed is fixed.
*/
`timescale 1ns/1ns
`include "ltu_map.svh"
module logical_address_test_unit_test;
   import ltu_pkg::*;
   logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, slow = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, ret_addr, fnext, caddr, faddr, e_ret, r_addr, data_v, spc_v;
   logic [31:0] s_addr, ea_v;
   logic pready, pslverr, creq, freq, fvld, fberr, exc_vld, ret_vld, done;
   logic s_done, s_exc, s_ret;
   logic [3:0] cspace, s_space, fault_lvl = 4'h8;
   logic [2:0] acc = '0, ret_reg, s_reg;
   logic [7:0] exc_vec, s_vec;
   logic [15:0] e_stat, e_mask;
   ltu_cache_t crsp, cent = '0;
   ltu_desc_t fdesc, root = '0, tbl [8] = '{default: '0};
   int n_mismatch = 0, tests_run = 0, n_fetch, n_look, e_nf;

   ltu_test_unit dut (.CORE_CLK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(pen),
      .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .CACHE_REQ(creq), .CACHE_ADDR(caddr), .CACHE_SPACE(cspace),
      .CACHE_RSP(crsp), .ACC_LEVEL(acc), .FETCH_REQ(freq), .FETCH_ADDR(faddr),
      .FETCH_VLD(fvld), .FETCH_FETCH_FAULT_BIT(fberr), .FETCH_DESC(fdesc), .FETCH_NEXT(fnext),
      .ROOT_DESC(root), .ROOT_NEXT(32'h1000), .EXC_VLD(exc_vld), .EXC_VEC(exc_vec),
      .RET_VLD(ret_vld), .RET_REG(ret_reg), .RET_ADDR(ret_addr), .DONE(done));
   ltu_walk_model mem (.CORE_CLK(clk), .RESETN(rstn), .CACHE_REQ(creq), .CACHE_RSP(crsp),
      .FETCH_REQ(freq), .FETCH_ADDR(faddr), .FETCH_VLD(fvld), .FETCH_FETCH_FAULT_BIT(fberr),
      .FETCH_DESC(fdesc), .FETCH_NEXT(fnext), .cache_ent(cent), .tbl(tbl),
      .fault_lvl(fault_lvl), .slow(slow));

   initial forever #20 clk = ~clk;

   // Pulses stand one cycle, so they are latched just after each edge
   always @(posedge clk) begin
      #1;
      if (done) s_done = 1;
      if (exc_vld) s_exc = 1;
      if (exc_vld) s_vec = exc_vec;
      if (ret_vld) s_ret = 1;
      if (ret_vld) s_reg = ret_reg;
      if (ret_vld) r_addr = ret_addr;
      if (creq) s_space = cspace;
      if (creq) s_addr = caddr;
      if (creq) n_look++;
      if (freq) n_fetch++;
   end

   task automatic conclude();
      if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
      int t;
      @(posedge clk);
      {psel, pwr, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge clk);
      pen <= 1'b1;
      t = 0;
      do begin
         @(posedge clk);
         #1;
         t++;
      end while (pready !== 1'b1 && t < 20);
      q = prdata;
      err = pslverr;
      @(posedge clk);
      {psel, pen} <= 2'b00;
      if (t >= 20) chk("pready", 1, 0);
   endtask

   task automatic run(input logic [15:0] cmd);
      logic [31:0] q;
      logic e;
      int t;
      {s_done, s_exc, s_ret} = 3'b000;
      n_look = 0;
      n_fetch = 0;
      apb(1, `LTU_CMD_OFS, {16'h0, cmd}, q, e);
      for (t = 0; !s_done && t < 100; t++) @(posedge clk);
      if (!s_done) chk("done", 1, 0);
   endtask

   function automatic logic [3:0] fc_of(input logic [4:0] f);
      if (f[4]) return f[3:0];
      if (f[3]) return data_v[3:0];
      return f[0] ? {1'b0, spc_v[6:4]} : {1'b0, spc_v[2:0]};
   endfunction

   function automatic void predict(input logic [15:0] cmd);
      logic [3:0] fc;
      ltu_desc_t x;
      fc = fc_of(cmd[4:0]);
      {e_stat, e_ret, e_nf, e_mask} = {16'h0, 32'h0, 32'h0, 16'hefc7};
      if (cmd[15:13] == 3'd0) begin
         e_mask = 16'h87c7;
         e_stat[15:6] = {cent.fetch_fault_bit, 4'h0, cent.wp, 1'b0, cent.mod, cent.gate, cent.shared};
         e_stat[15:6] = e_stat[15:6] & {10{cent.hit}};
         e_stat[9] = ~cent.hit;
      end else if (root.dtype != 2'd1) begin
         e_stat[9] = 1'b1;
         for (int k = 0; k < cmd[15:13]; k++) begin
            x = tbl[k];
            e_nf = k + 1;
            if (k == fault_lvl) begin
               e_stat[15] = 1'b1;
               e_mask = 16'hefc0;
               break;
            end
            e_ret = 32'h1000 + 32'(4 * k);
            e_stat[2:0] = 3'(k + 1);
            e_stat[14] |= x.is_long & x.lim_hit;
            e_stat[13] |= x.is_long & x.sup & ~fc[2];
            e_stat[11] |= x.is_long & (acc > x.read_access_level | (!cmd[12] & acc > x.write_access_level));
            e_stat[10] |= x.wp | (x.is_long & acc > x.write_access_level);
            if (x.dtype == 2'd1) e_stat[9:6] = {1'b0, x.mod, x.gate, x.shared};
            if (x.dtype < 2'd2 || e_stat[14]) break;
         end
      end
   endfunction

   task automatic probe();
      logic [31:0] q;
      logic e;
      logic [15:0] c;
      int k;
      foreach (tbl[i]) tbl[i] <= ltu_desc_t'(15'($urandom));
      cent <= ltu_cache_t'(7'($urandom));
      acc <= 3'($urandom);
      slow <= 1'($urandom);
      root.dtype <= ($urandom % 5 == 0) ? 2'd1 : 2'd2;
      fault_lvl <= ($urandom % 3 == 0) ? 4'(1 + $urandom % 7) : 4'h8;
      data_v = $urandom;
      spc_v = $urandom;
      apb(1, `LTU_DATA_OFS, data_v, q, e);
      apb(1, `LTU_SRC_OFS, spc_v, q, e);
      ea_v = $urandom;
      apb(1, `LTU_EA_OFS, ea_v, q, e);
      c = $urandom;
      k = $urandom % 4;
      c[7:0] = k == 0 ? {3'b000, 1'b1, c[3:0]} : k == 1 ? {5'b00001, c[2:0]} : 8'(k - 2);
      if ($urandom % 3 == 0) c[15:13] = 3'd0;
      if (c[15:13] == 3'd0) c[11:8] = 4'h0;
      run(c);
      predict(c);
      chk("exception", 0, s_exc);
      chk("lookups", c[15:13] == 3'd0, n_look);
      chk("fetches", e_nf, n_fetch);
      if (c[15:13] == 3'd0) chk("space code", fc_of(c[4:0]), s_space);
      if (c[15:13] == 3'd0) chk("cache addr", ea_v, s_addr);
      chk("return", c[11], s_ret);
      if (c[11]) chk("return reg", c[10:8], s_reg);
      if (c[11]) chk("return addr", e_ret, r_addr);
      apb(0, `LTU_STAT_OFS, 0, q, e);
      chk("status", e_stat & e_mask, q[15:0] & e_mask);
   endtask

   task automatic trap(input logic [31:0] ctl, input logic [15:0] cmd, input logic [7:0] vec);
      logic [31:0] q, q0;
      logic e;
      apb(0, `LTU_STAT_OFS, 0, q0, e);
      apb(1, `LTU_CTRL_OFS, ctl, q, e);
      run(cmd);
      chk("vector", {1'b1, vec}, {s_exc, s_vec});
      chk("activity", 0, n_look + n_fetch + s_ret);
      apb(0, `LTU_STAT_OFS, 0, q, e);
      chk("status kept", q0, q);
      apb(1, `LTU_CTRL_OFS, 32'h3, q, e);
   endtask

   initial begin
      logic [31:0] q;
      logic e;
      void'($urandom(32'ha6ab));
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      apb(0, `LTU_STAT_OFS, 0, q, e);
      chk("status reset", `LTU_STAT_RST, q);
      apb(1, `LTU_STAT_OFS, 32'hffff, q, e);
      apb(0, `LTU_STAT_OFS, 0, q, e);
      chk("status read only", `LTU_STAT_RST, q);
      apb(0, 12'h01c, 0, q, e);
      chk("unmapped error", 1, e);
      chk("unmapped data", 0, q);
      apb(1, `LTU_CTRL_OFS, 32'h3, q, e);
      repeat (60) probe();
      trap(32'h1, 16'h2000, `LTU_VEC_PRIV);
      trap(32'h0, 16'h0900, `LTU_VEC_PRIV);
      trap(32'h3, 16'h0800, `LTU_VEC_FLINE);
      trap(32'h2, 16'h2000, `LTU_VEC_ILLOP);
      conclude();
   end

   initial begin
      #2000000;
      n_mismatch++;
      conclude();
   end
endmodule

/* verification/ltu_walk_model.sv */
/*
 Descriptor memory and translation cache that the test unit searches.
 Assumes table bases step by four bytes from 32'h1000, one level per word.
*/
`timescale 1ns/1ns
module ltu_walk_model
   import ltu_pkg::*;
(
   input wire logic CORE_CLK, // Core clock
   input wire logic RESETN, // Asynchronous reset, active low
   input wire logic CACHE_REQ, // Lookup request
   output ltu_cache_t CACHE_RSP, // Lookup answer, the cycle after a request
   input wire logic FETCH_REQ, // Descriptor read request
   input wire logic [31:0] FETCH_ADDR, // Descriptor address
   output logic FETCH_VLD, // Read complete
   output logic FETCH_FETCH_FAULT_BIT, // Read ended abnormally
   output ltu_desc_t FETCH_DESC, // Descriptor read
   output logic [31:0] FETCH_NEXT, // Next table base
   input wire ltu_cache_t cache_ent, // Entry held for the tested address
   input wire ltu_desc_t tbl [8], // Descriptor of each level
   input wire logic [3:0] fault_lvl, // Level whose read faults, 8 for none
   input wire logic slow // Stretch each read by three cycles
);
   logic rsp_q, busy_q, junk_q;
   logic [1:0] wait_q;
   logic [31:0] addr_q;
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         {rsp_q, busy_q, junk_q, wait_q, addr_q, FETCH_VLD} <= '0;
      end else begin
         rsp_q <= CACHE_REQ;
         junk_q <= ~junk_q;
         FETCH_VLD <= busy_q && wait_q == 2'd0;
         if (FETCH_REQ) begin
            busy_q <= 1'b1;
            wait_q <= slow ? 2'd3 : 2'd0;
            addr_q <= FETCH_ADDR;
         end else if (wait_q != 2'd0) begin
            wait_q <= wait_q - 2'd1;
         end else begin
            busy_q <= 1'b0;
         end
      end
   end
   // Lines outside an answer toggle, so a stale value can never pass for data
   assign CACHE_RSP = rsp_q ? cache_ent : ltu_cache_t'({7{junk_q}});
   assign FETCH_DESC = FETCH_VLD ? tbl[addr_q[4:2]] : ltu_desc_t'({15{junk_q}});
   assign FETCH_FETCH_FAULT_BIT = FETCH_VLD ? (fault_lvl == {1'b0, addr_q[4:2]}) : junk_q;
   assign FETCH_NEXT = FETCH_VLD ? addr_q + 32'h4 : {32{junk_q}};
endmodule
